//--- include/sds_pkg.sv
// Shared constants and types of the serial datagram slave
package sds_pkg;
  localparam int unsigned FRAME_BITS = 40;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] FRAME_CNT = 6'h28;
  localparam logic [CNT_W-1:0] FIRST_CNT = 6'h01;
  localparam int unsigned WRITE_BIT = 39;
  localparam int unsigned ADDR_HI = 38;
  localparam int unsigned ADDR_LO = 32;
  localparam int unsigned STAT_HI = 39;
  localparam int unsigned STAT_LO = 32;
  localparam int unsigned ST_RSVD = 7;
  localparam int unsigned ST_STOP_L2 = 6;
  localparam int unsigned ST_STOP_L1 = 5;
  localparam int unsigned ST_VEL2 = 4;
  localparam int unsigned ST_VEL1 = 3;
  localparam int unsigned ST_DRV_ERR2 = 2;
  localparam int unsigned ST_DRV_ERR1 = 1;
  localparam int unsigned ST_RESET = 0;
  localparam logic [ADDR_W-1:0] GLOBAL_STATUS_ADDR = 7'h01;
  localparam logic [2:0] GLOBAL_STATUS_RST = 3'h1;
  localparam logic [DATA_W-1:0] REPLY_RST = 32'h00000000;
  localparam logic [7:0] STATUS_RST = 8'h00;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sds_cmd_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic ob_meta;
    logic ob_sync;
    logic [7:0] status_q;
    logic [DATA_W-1:0] pend_data;
    logic rd_pend;
    logic [2:0] global_status_reg;
    sds_cmd_t cmd;
    logic cmd_valid;
    logic sout;
    logic soe;
  } sds_sys_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [FRAME_BITS-1:0] shift;
  } sds_link_t;
endpackage

//--- src/sds_slave.sv
// Serial datagram slave port with status byte and pipelined read-back
// Notes on behaviour
// [R01] Datagram is 40 bits: address, four data bytes
// [R02] Master keeps select low whole datagram
// [R03] Bit 39 high means write, else read
// [R04] Read data returns in next datagram
// [R05] After write, reply mirrors that write data
// [R06] Read ignores data bits, no register update
// [R07] Status byte sits in reply bits 39..32
// [R08] Bit7 zero, bits 6,5 left stop switches
// [R09] Bits 4,3 target velocity reached flags
// [R10] Bits 2,1 driver faults, cleared by status read
// [R11] Bit0 reset flag, cleared by status read
// [R12] Every register moves as full 32-bit word
// [R13] Values right aligned, integers two's complement
// [R14] Sample rising edge, drive after falling, MSB first
// [R15] Master gives at least 40 clocks per frame
// [R16] Excess input bits emerge 40 clocks later
// [R17] Select rising commits shift register as command
// [R18] Only last 40 bits before release count
// [R19] Serial output driven only while select low
// [R20] Serial clock at most half system clock
// [R21] Reply loaded before first serial clock edge
`timescale 1ns/1ps
module sds_slave
  import sds_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_serial_clk,
  input wire logic i_select_low_in,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_serial_out_en,
  input wire logic i_stop_left_1,
  input wire logic i_stop_left_2,
  input wire logic i_vel_reached_1,
  input wire logic i_vel_reached_2,
  input wire logic i_driver_error_1,
  input wire logic i_driver_error_2,
  input wire logic [DATA_W-1:0] i_rd_data,
  output sds_cmd_t o_cmd,
  output logic o_cmd_valid,
  output logic [2:0] o_global_status
);
  sds_sys_t s_reg;
  sds_sys_t s_next;
  sds_link_t l_reg;
  sds_link_t l_next;
  logic started_reg;
  logic ob_flip_reg;
  logic [FRAME_BITS-1:0] reply_word;
  logic [7:0] live_status;
  logic cs_rise;
  logic status_read;

  // Frozen while select is low, so safe to read from the link side
  assign reply_word = {s_reg.status_q, s_reg.pend_data}; // [R07] [R12]

  always_comb begin
    live_status = STATUS_RST;
    live_status[ST_RSVD] = 1'b0; // [R08]
    live_status[ST_STOP_L2] = i_stop_left_2; // [R08]
    live_status[ST_STOP_L1] = i_stop_left_1; // [R08]
    live_status[ST_VEL2] = i_vel_reached_2; // [R09]
    live_status[ST_VEL1] = i_vel_reached_1; // [R09]
    live_status[ST_DRV_ERR2] = s_reg.global_status_reg[2]; // [R10]
    live_status[ST_DRV_ERR1] = s_reg.global_status_reg[1]; // [R10]
    live_status[ST_RESET] = s_reg.global_status_reg[0]; // [R11]
  end

  // Link side: capture on rising serial clock
  always_comb begin
    l_next = l_reg;
    if (!started_reg) begin
      l_next.shift = {reply_word[FRAME_BITS-2:0], i_serial_in}; // [R14] [R21]
      l_next.cnt = FIRST_CNT;
    end else begin
      l_next.shift = {l_reg.shift[FRAME_BITS-2:0], i_serial_in}; // [R14] [R16] [R18]
      if (l_reg.cnt != FRAME_CNT) begin
        l_next.cnt = l_reg.cnt + FIRST_CNT; // [R01]
      end
    end
  end

  always_ff @(posedge i_serial_clk) begin
    l_reg <= l_next;
  end

  // Cleared by select high, marks the first edge of a frame
  always_ff @(posedge i_serial_clk or posedge i_select_low_in) begin
    if (i_select_low_in) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // Output bit kept relative to reply MSB so one synced bit suffices
  always_ff @(negedge i_serial_clk or posedge i_select_low_in) begin
    if (i_select_low_in) begin
      ob_flip_reg <= 1'b0;
    end else begin
      ob_flip_reg <= l_reg.shift[FRAME_BITS-1] ^ reply_word[FRAME_BITS-1]; // [R14] [R16]
    end
  end

  assign cs_rise = s_reg.cs_sync & ~s_reg.cs_prev;
  assign status_read = s_reg.cmd_valid & ~s_reg.cmd.write &
    (s_reg.cmd.addr == GLOBAL_STATUS_ADDR);

  // System side
  always_comb begin
    s_next = s_reg;
    s_next.cs_meta = i_select_low_in; // [R20]
    s_next.cs_sync = s_reg.cs_meta;
    s_next.cs_prev = s_reg.cs_sync;
    s_next.ob_meta = ob_flip_reg;
    s_next.ob_sync = s_reg.ob_meta;
    s_next.cmd_valid = 1'b0;
    if (s_reg.cs_sync) begin
      s_next.status_q = live_status; // [R21]
    end
    if (s_reg.rd_pend) begin
      s_next.pend_data = i_rd_data; // [R04]
      s_next.rd_pend = 1'b0;
    end
    if (cs_rise && (l_reg.cnt == FRAME_CNT)) begin // [R15] [R17] [R18]
      s_next.cmd_valid = 1'b1;
      s_next.cmd.write = l_reg.shift[WRITE_BIT]; // [R03]
      s_next.cmd.addr = l_reg.shift[ADDR_HI:ADDR_LO]; // [R03]
      s_next.cmd.data = l_reg.shift[DATA_W-1:0]; // [R13]
      if (l_reg.shift[WRITE_BIT]) begin
        s_next.pend_data = l_reg.shift[DATA_W-1:0]; // [R05]
        s_next.rd_pend = 1'b0;
      end else begin
        s_next.rd_pend = 1'b1; // [R06]
      end
    end
    // Set beats clear in the same cycle
    s_next.global_status_reg = (status_read ? 3'h0 : s_reg.global_status_reg) |
      {i_driver_error_2, i_driver_error_1, 1'b0}; // [R10] [R11]
    s_next.soe = ~s_reg.cs_sync; // [R19]
    s_next.sout = reply_word[FRAME_BITS-1] ^ s_reg.ob_sync; // [R14]
    if (!i_reset_n) begin
      s_next.cs_meta = 1'b1;
      s_next.cs_sync = 1'b1;
      s_next.cs_prev = 1'b1;
      s_next.ob_meta = 1'b0;
      s_next.ob_sync = 1'b0;
      s_next.status_q = STATUS_RST;
      s_next.pend_data = REPLY_RST;
      s_next.rd_pend = 1'b0;
      s_next.global_status_reg = GLOBAL_STATUS_RST; // [R11]
      s_next.cmd = '0;
      s_next.cmd_valid = 1'b0;
      s_next.sout = 1'b0;
      s_next.soe = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_reg <= s_next;
  end

  assign o_serial_out = s_reg.sout;
  assign o_serial_out_en = s_reg.soe;
  assign o_cmd = s_reg.cmd;
  assign o_cmd_valid = s_reg.cmd_valid;
  assign o_global_status = s_reg.global_status_reg;
endmodule

//--- verification/sds_master.sv
// Serial master model sending datagrams
`timescale 1ns/1ps
module sds_master (
  input wire logic i_sdo,
  output logic o_sclk = 1'b0,
  output logic o_csn = 1'b0,
  output logic o_sdi = 1'b0
);
  // Early select rise clears the slave's frame-start flag
  initial #1 o_csn = 1'b1;
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    #3 o_csn = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = tx[i];
      #40 o_sclk = 1'b1;
      rx[i] = i_sdo;
      #40 o_sclk = 1'b0;
    end
    #20 o_csn = 1'b1;
    #90;
  endtask
endmodule

//--- verification/sds_slave_sva.sv
// Port assertions of the serial datagram slave
`timescale 1ns/1ps
module sds_slave_sva
  import sds_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_select_low_in,
  input wire logic i_driver_error_1,
  input wire logic o_serial_out_en,
  input wire sds_cmd_t o_cmd,
  input wire logic o_cmd_valid,
  input wire logic [2:0] o_global_status
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  wire rd_gs = !o_cmd.write && o_cmd.addr == GLOBAL_STATUS_ADDR;
  AST_EN_OFF: assert property (i_select_low_in [*4] |-> !o_serial_out_en) else $error("en");
  AST_EN_ON: assert property (!i_select_low_in [*5] |-> o_serial_out_en) else $error("en");
  AST_PULSE: assert property (o_cmd_valid |=> !o_cmd_valid) else $error("pulse");
  AST_VALID: assert property (o_cmd_valid |-> $past(i_select_low_in, 3)) else $error("vld");
  AST_HOLD: assert property (!o_cmd_valid |-> $stable(o_cmd)) else $error("cmd");
  AST_RST: assert property ($rose(i_reset_n) |-> o_global_status == GLOBAL_STATUS_RST)
    else $error("rst");
  AST_ERR: assert property (i_driver_error_1 |=> o_global_status[1]) else $error("err");
  AST_CLR: assert property ($fell(o_global_status[2]) |-> $past(rd_gs)) else $error("clr");
  COV_WR: cover property (o_cmd_valid && o_cmd.write);
  COV_RD: cover property (o_cmd_valid && rd_gs);
  COV_CLR: cover property ($fell(o_global_status[1]));
endmodule
bind sds_slave sds_slave_sva chk (.*);

//--- verification/sds_slave_test.sv
// Self-checking bench of the serial datagram slave
`timescale 1ns/1ps
module sds_slave_test;
  import sds_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] sw = 4'h0;
  logic [1:0] err = 2'h0;
  logic [DATA_W-1:0] rd = 32'h0;
  logic [DATA_W-1:0] e_rep = 32'h0;
  logic [2:0] e_gst = 3'h1;
  int n_errors = 0;
  int n_compared = 0;
  int n_vld = 0;
  wire sclk, select_low_in, serial_in, serial_out, en, vld;
  wire [2:0] gst;
  sds_cmd_t cmd;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) n_vld += (vld === 1'b1);
  sds_slave dut (.i_ref_clk, .i_reset_n, .i_serial_clk(sclk), .i_select_low_in(select_low_in),
    .i_serial_in(serial_in), .o_serial_out(serial_out), .o_serial_out_en(en), .i_stop_left_1(sw[0]),
    .i_stop_left_2(sw[1]), .i_vel_reached_1(sw[2]), .i_vel_reached_2(sw[3]),
    .i_driver_error_1(err[0]), .i_driver_error_2(err[1]), .i_rd_data(rd), .o_cmd(cmd),
    .o_cmd_valid(vld), .o_global_status(gst));
  sds_master m (.i_sdo(en ? serial_out : ~serial_out), .o_sclk(sclk), .o_csn(select_low_in), .o_sdi(serial_in));
  task automatic test_done;
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic frame(input int n, input logic [47:0] tx);
    logic [47:0] ex, rx;
    int v;
    v = n_vld;
    ex = {1'b0, sw[1], sw[0], sw[3], sw[2], e_gst, e_rep, tx[47:40]} >> (48 - n);
    m.xfer(n, tx, rx);
    chk(rx, ex);
    if (n >= 40) begin
      chk(tx[39] ? cmd : {cmd[39:32], tx[31:0]}, tx[39:0]);
      e_rep = tx[39] ? tx[31:0] : rd;
      if (!tx[39] && tx[38:32] == GLOBAL_STATUS_ADDR) e_gst = 3'h0;
    end
    chk(n_vld - v, n >= 40);
    chk(gst, e_gst);
  endtask
  initial begin
    logic [47:0] tx;
    void'($urandom(30));
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    chk(gst, 3'h1);
    for (int k = 0; k < 40; k++) begin
      @(posedge i_ref_clk);
      sw <= $urandom;
      rd <= $urandom;
      err <= (k % 5 == 2) ? 2'($urandom) : 2'h0;
      @(posedge i_ref_clk);
      err <= 2'h0;
      e_gst = e_gst | {err, 1'b0};
      tx = {8'($urandom), 1'($urandom), 7'($urandom % 3), $urandom};
      if (k == 0) tx = 48'h0001FFFFFFFF;
      frame(k == 7 ? 30 : (k % 6 == 3 ? 48 : 40), tx);
    end
    test_done();
  end
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
endmodule
